/* File: adc_conversion_sequencer.sv */
// successive-approximation conversion sequencer
//
// Overview of operation
// - standby halts all conversion activity
// - run clear stops; ref follows ref enable bit
// - coincident result read completes before update
// - trigger edges ignored while converting
// - mode/channel write at end suppresses result
// - channel write leaves done flag unchanged
// - done may reflect previously selected channel
// - ref enabled first result is valid
// - ref disabled first result marked undefined
// - stop at conversion end voids result
// - software start repeats until run cleared
// - register write aborts and restarts conversion
// - trigger mode waits for edge, converts once
// - eight decisions latch result, raise done
`timescale 1ns/1ps
module adc_conversion_sequencer
  import adc_seq_pkg::*;
#(
  parameter int unsigned SAMPLE_CYC = SAMPLE_CYCLES,
  parameter int unsigned STEP_CYC   = STEP_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       clk_en,
  input  wire logic       standby,
  input  wire logic       mode_wr,
  input  wire logic [7:0] mode_wdata,
  input  wire logic       chan_wr,
  input  wire logic [2:0] chan_wdata,
  input  wire logic       result_rd,
  input  wire logic       done_clr,
  input  wire logic       trigger_input_pin,
  input  wire logic       comparator_out,
  output logic [7:0]      converter_mode_reg,
  output logic [2:0]      channel_select_reg,
  output logic [7:0]      result_reg,
  output logic [7:0]      result_rdata,
  output logic            result_undefined,
  output logic            conversion_done_irq,
  output logic            done_flag,
  output logic            busy,
  output logic            ref_on,
  output logic            sample_en,
  output logic [2:0]      mux_sel,
  output logic [7:0]      dac_code
);

  typedef enum logic [1:0] {IDLE, WAIT_TRIG, SAMPLE, STEP} state_e;

  localparam int unsigned CW = 8;

  state_e          state_r, state_nxt;
  logic [CW-1:0]   cnt_r, cnt_nxt;
  logic [2:0]      bit_r, bit_nxt;
  logic [7:0]      sar_r, sar_nxt;
  logic [2:0]      conv_chan_r;
  logic            first_r;
  logic            first_undef_r;
  logic            trig_q_r;

  wire run       = converter_mode_reg[RUN_BIT];
  wire trig_mode = converter_mode_reg[TRIG_SEL_BIT];
  wire ref_en    = converter_mode_reg[REF_EN_BIT];
  wire new_run   = mode_wdata[RUN_BIT];
  wire new_trig  = mode_wdata[TRIG_SEL_BIT];
  wire new_ref   = mode_wdata[REF_EN_BIT];
  wire reg_wr    = mode_wr | chan_wr;
  wire active    = (state_r == SAMPLE) | (state_r == STEP);
  wire trig_edge = converter_mode_reg[EDGE_LO_BIT]
                 ? (trigger_input_pin & ~trig_q_r)
                 : (~trigger_input_pin & trig_q_r);
  wire step_done = (cnt_r == CW'(STEP_CYC - 1));
  wire last_bit  = (bit_r == 3'h0);
  // eight decisions complete, no coincident register write or standby
  wire conv_end  = (state_r == STEP) & step_done & last_bit;
  wire commit    = conv_end & ~reg_wr & ~standby;
  wire eff_run   = mode_wr ? new_run : run;
  wire eff_trig  = mode_wr ? new_trig : trig_mode;
  wire decided   = sar_r[bit_r] ? comparator_out : 1'b0;
  wire [7:0] sar_final = {sar_r[7:1], decided};
  wire ref_state = mode_wr ? new_ref : ref_en;
  wire samp_start = (state_nxt == SAMPLE) & ((state_r != SAMPLE) | reg_wr);

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    bit_nxt   = bit_r;
    sar_nxt   = sar_r;
    if (standby || !eff_run) begin
      state_nxt = IDLE;
    end else if (reg_wr) begin
      state_nxt = eff_trig ? WAIT_TRIG : SAMPLE;
      cnt_nxt   = '0;
    end else begin
      unique case (state_r)
        IDLE: begin
          state_nxt = trig_mode ? WAIT_TRIG : SAMPLE;
          cnt_nxt   = '0;
        end
        WAIT_TRIG: begin
          if (trig_edge) begin
            state_nxt = SAMPLE;
          end
          cnt_nxt = '0;
        end
        SAMPLE: begin
          cnt_nxt = cnt_r + CW'(1);
          if (cnt_r == CW'(SAMPLE_CYC - 1)) begin
            state_nxt = STEP;
            cnt_nxt   = '0;
            bit_nxt   = 3'h7;
            sar_nxt   = 8'h80;
          end
        end
        STEP: begin
          cnt_nxt = cnt_r + CW'(1);
          if (step_done) begin
            cnt_nxt = '0;
            sar_nxt = sar_r;
            sar_nxt[bit_r] = decided;
            if (last_bit) begin
              state_nxt = trig_mode ? WAIT_TRIG : SAMPLE;
            end else begin
              bit_nxt = bit_r - 3'h1;
              sar_nxt[bit_r - 3'h1] = 1'b1;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r  <= IDLE;
      cnt_r    <= '0;
      bit_r    <= 3'h7;
      sar_r    <= 8'h00;
      trig_q_r <= 1'b0;
    end else if (clk_en) begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      bit_r    <= bit_nxt;
      sar_r    <= sar_nxt;
      trig_q_r <= trigger_input_pin;
    end
  end

  // registers written by software
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      converter_mode_reg <= MODE_RST;
      channel_select_reg <= CHAN_RST;
    end else if (clk_en) begin
      if (mode_wr) begin
        converter_mode_reg <= mode_wdata;
      end
      if (chan_wr) begin
        channel_select_reg <= chan_wdata;
      end
    end
  end

  // channel latched at sampling start; done keeps old channel
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      conv_chan_r <= CHAN_RST;
    end else if (clk_en && samp_start) begin
      conv_chan_r <= chan_wr ? chan_wdata : channel_select_reg;
    end
  end

  // first result after a start, and whether ref was off then
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      first_r       <= 1'b1;
      first_undef_r <= 1'b0;
    end else if (clk_en) begin
      if (state_r == IDLE && state_nxt != IDLE) begin
        first_r       <= 1'b1;
        first_undef_r <= ~ref_state;
      end else if (commit) begin
        first_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // result, read port and flags
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      result_reg          <= RESULT_RST;
      result_rdata        <= RESULT_RST;
      result_undefined    <= 1'b1;
      conversion_done_irq <= 1'b0;
      done_flag           <= 1'b0;
    end else if (clk_en) begin
      if (result_rd) begin
        result_rdata <= result_reg;
      end
      if (commit) begin
        result_reg       <= sar_final;
        result_undefined <= first_r & first_undef_r;
      end else if (conv_end && !eff_run) begin
        result_undefined <= 1'b1;
      end
      conversion_done_irq <= commit;
      if (commit) begin
        done_flag <= 1'b1; // set beats clear
      end else if (done_clr) begin
        done_flag <= 1'b0;
      end
    end
  end

  // analog-side controls
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busy      <= 1'b0;
      ref_on    <= 1'b0;
      sample_en <= 1'b0;
      mux_sel   <= CHAN_RST;
      dac_code  <= 8'h00;
    end else if (clk_en) begin
      busy      <= (state_nxt == SAMPLE) | (state_nxt == STEP);
      ref_on    <= ref_state & ~standby;
      sample_en <= (state_nxt == SAMPLE);
      mux_sel   <= samp_start
                 ? (chan_wr ? chan_wdata : channel_select_reg)
                 : conv_chan_r;
      dac_code  <= sar_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  standby_halts_a: assert property (clk_en && standby |=> !busy)
    else $error("busy during standby");
  stop_halts_a: assert property (
    clk_en && mode_wr && !new_run |=> !busy && state_r == IDLE)
    else $error("conversion kept running after stop");
  write_wins_a: assert property (
    conv_end && reg_wr && clk_en |=> !conversion_done_irq)
    else $error("done raised despite register write");
  result_latch_a: assert property (
    commit && clk_en |=> conversion_done_irq
      && result_reg == $past(sar_final))
    else $error("result not latched at end");
  read_old_a: assert property (
    result_rd && commit && clk_en |=> result_rdata == $past(result_reg))
    else $error("coincident read saw new result");
  trig_ignored_a: assert property (
    clk_en && active && trig_mode && !reg_wr && !conv_end && run
      && !standby |=> state_r != WAIT_TRIG)
    else $error("conversion left on trigger edge");
  chan_keeps_done_a: assert property (
    clk_en && chan_wr && !done_clr && !commit
      |=> done_flag == $past(done_flag))
    else $error("channel write changed done flag");
  restart_a: assert property (
    clk_en && reg_wr && eff_run && !eff_trig && !standby
      |=> state_r == SAMPLE && cnt_r == '0)
    else $error("write did not restart conversion");
  chan_restart_a: assert property (
    clk_en && samp_start && chan_wr |=> mux_sel == $past(chan_wdata))
    else $error("restart kept the old channel");
  continuous_a: assert property (
    clk_en && conv_end && !reg_wr && !trig_mode && run && !standby
      |=> state_r == SAMPLE)
    else $error("software mode did not repeat");
  trig_wait_a: assert property (
    clk_en && state_r == WAIT_TRIG && !trig_edge && !reg_wr && run
      && !standby |=> state_r == WAIT_TRIG)
    else $error("left trigger wait without edge");

  soft_conv_c: cover property (commit && !trig_mode);
  trig_conv_c: cover property (commit && trig_mode);
  write_at_end_c: cover property (conv_end && reg_wr);
  read_at_end_c: cover property (commit && result_rd);

endmodule // adc_conversion_sequencer

/* File: adc_seq_pkg.sv */
// constants for the conversion sequencer
package adc_seq_pkg;
  localparam int unsigned RUN_BIT        = 7;
  localparam int unsigned TRIG_SEL_BIT   = 6;
  localparam int unsigned REF_EN_BIT     = 0;
  localparam int unsigned EDGE_LO_BIT    = 1;
  localparam int unsigned EDGE_HI_BIT    = 2;
  localparam int unsigned SAR_BITS       = 8;
  localparam int unsigned CHAN_BITS      = 3;
  localparam logic [7:0]  MODE_RST       = 8'h00;
  localparam logic [2:0]  CHAN_RST       = 3'h0;
  localparam logic [7:0]  RESULT_RST     = 8'h00;
  localparam int unsigned SAMPLE_CYCLES  = 4;
  localparam int unsigned STEP_CYCLES    = 2;
endpackage

/* File: adc_front_model.sv */
// analog front end model: sample and hold plus comparator
`timescale 1ns/1ps
module adc_front_model (
  input  wire logic        clock,
  input  wire logic        sample_en,
  input  wire logic [2:0]  mux_sel,
  input  wire logic [7:0]  dac_code,
  input  wire logic [63:0] levels,
  output logic             comparator_out
);
  logic [7:0] held_r;
  // hold the selected level while sampling
  always_ff @(posedge clock) begin
    if (sample_en) begin
      held_r <= levels[{mux_sel, 3'h0} +: 8];
    end
  end
  // input at or above the tap gives 1
  assign comparator_out = (held_r >= dac_code);
endmodule // adc_front_model

/* File: adc_conversion_sequencer_test.sv */
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module adc_conversion_sequencer_test;
  import adc_seq_pkg::*;
  logic        clock, rst, standby, trig, comp, ce;
  logic [3:0]  stb;
  logic [7:0]  wdata, mode_q, res_q, rdata_q, dac;
  logic [2:0]  chan_q, mux;
  logic [63:0] levels;
  logic        undef, irq, done, busy, ref_on, samp;
  int          errors, num_checks, irqs, p, t, n0;

  adc_conversion_sequencer u_adc_conversion_sequencer (
    .clock(clock), .rst(rst), .clk_en(ce), .standby(standby),
    .mode_wr(stb[0]), .mode_wdata(wdata), .chan_wr(stb[1]),
    .chan_wdata(wdata[2:0]), .result_rd(stb[2]), .done_clr(stb[3]),
    .trigger_input_pin(trig), .comparator_out(comp),
    .converter_mode_reg(mode_q), .channel_select_reg(chan_q),
    .result_reg(res_q), .result_rdata(rdata_q), .result_undefined(undef),
    .conversion_done_irq(irq), .done_flag(done), .busy(busy),
    .ref_on(ref_on), .sample_en(samp), .mux_sel(mux), .dac_code(dac));
  adc_front_model u_adc_front_model (
    .clock(clock), .sample_en(samp), .mux_sel(mux), .dac_code(dac),
    .levels(levels), .comparator_out(comp));

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(negedge clock) begin
    if (irq === 1'b1) begin
      irqs++;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string w, input logic [7:0] s, e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("FAIL %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic give_verdict();
    if (errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic strobe(input int k, input logic [7:0] v);
    @(posedge clock);
    wdata <= v;
    stb   <= 4'h1 << k;
    @(posedge clock);
    stb   <= 4'h0;
  endtask
  task automatic wait_irq(output int n);
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (irq !== 1'b1 && n < 200);
    check("irq", {7'h0, irq}, 8'h01);
  endtask
  // land a strobe on the edge where the next result commits
  task automatic at_end(input int k, input logic [7:0] v, nl);
    wait_irq(t);
    levels[47:40] = nl;
    strobe(3, 8'h00);
    repeat (p - 4) @(posedge clock);
    strobe(k, v);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    errors++;
    give_verdict();
  end
  initial begin
    {rst, standby, trig, stb, wdata} = '0;
    rst = 1'b1;
    ce = 1'b1;
    levels = 64'hf0e1_d2c3_b4a5_9687; // pins never read as port
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    strobe(1, 8'h03);
    strobe(0, 8'h81);
    wait_irq(t);
    check("result", res_q, 8'hb4);
    check("undef", {7'h0, undef}, 8'h00);
    check("done", {7'h0, done}, 8'h01);
    wait_irq(p);
    check("repeat", res_q, 8'hb4);
    strobe(1, 8'h05);
    #1;
    check("done kept", {7'h0, done}, 8'h01);
    wait_irq(t);
    check("new chan", res_q, 8'hd2);
    at_end(2, 8'h00, 8'h3c);
    check("rd data", rdata_q, 8'hd2);
    check("rd then wr", res_q, 8'h3c);
    at_end(0, 8'h81, 8'h77);
    check("wr wins", res_q, 8'h3c);
    check("no done", {7'h0, done}, 8'h00);
    wait_irq(t);
    check("restart", res_q, 8'h77);
    strobe(2, 8'h00);
    #1;
    check("pre-stop rd", rdata_q, 8'h77);
    at_end(0, 8'h01, 8'h77); // result read before the stop
    repeat (3) @(posedge clock);
    #1;
    check("stop end", {7'h0, undef}, 8'h01);
    check("stopped", {7'h0, busy}, 8'h00);
    strobe(0, 8'h00);
    n0 = irqs;
    repeat (60) @(posedge clock);
    #1;
    check("ref off", {7'h0, ref_on}, 8'h00);
    check("no irq", irqs[7:0], n0[7:0]);
    strobe(3, 8'h00);
    strobe(0, 8'h80);
    wait_irq(t);
    check("first", {7'h0, undef}, 8'h01);
    wait_irq(t);
    check("second", {7'h0, undef}, 8'h00);
    @(posedge clock);
    ce <= 1'b0;
    n0 = irqs;
    repeat (30) @(posedge clock);
    #1;
    check("frozen busy", {7'h0, busy}, 8'h01);
    check("frozen irq", irqs[7:0], n0[7:0]);
    @(posedge clock);
    ce <= 1'b1;
    standby <= 1'b1;
    n0 = irqs;
    repeat (60) @(posedge clock);
    #1;
    check("sb busy", {7'h0, busy}, 8'h00);
    check("sb irq", irqs[7:0], n0[7:0]);
    @(posedge clock);
    standby <= 1'b0;
    strobe(0, 8'hc3);
    n0 = irqs;
    repeat (40) @(posedge clock);
    check("wait trig", irqs[7:0], n0[7:0]);
    trig <= 1'b1;
    repeat (6) @(posedge clock);
    trig <= 1'b0;
    repeat (2) @(posedge clock);
    trig <= 1'b1;
    repeat (80) @(posedge clock);
    #1;
    check("one conv", irqs[7:0], n0[7:0] + 8'h01);
    check("trig res", res_q, 8'h77);
    strobe(0, 8'hc1);
    trig <= 1'b0;
    repeat (30) @(posedge clock);
    #1;
    check("fall conv", irqs[7:0], n0[7:0] + 8'h02);
    give_verdict();
  end
endmodule // adc_conversion_sequencer_test
